/* design/virtual_signal_bank.sv */
// bank of 64 logical outputs and 32 command-driven logical inputs with events
// Operation
// [R1] 64 independent logical outputs from user logic
// [R2] outputs usable as controls for other functions
// [R3] output states readable by supervisory system
// [R4] 32 logical inputs set only by commands
// [R5] controller changes inputs only through commands
// [R6] inputs forced to zero on reboot
// [R7] latching mode holds 1 until zero command
// [R8] pulse mode returns to zero after 5 ms
// [R9] falling-edge delay can lengthen input pulse
// [R10] selectable ON/OFF events on every change; a change not yet sent is overwritten by the next one on that signal
// [R11] each event carries change time stamp
// [R12] events grouped: outputs low, outputs high, inputs
// [R13] pulse timed by millisecond tick, restarted
module virtual_signal_bank
   import vsig_pkg::*;
#(
   parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic [NUM_OUT-1:0]   out_value,
   output logic      [NUM_OUT-1:0]   out_state,
   input  wire logic                 cmd_valid,
   input  wire logic [IN_IDX_W-1:0]  cmd_index,
   input  wire logic                 cmd_value,
   input  wire logic [NUM_IN-1:0]    in_pulse_mode,
   input  wire logic [STRETCH_W-1:0] stretch_ms,
   output logic      [NUM_IN-1:0]    in_state,
   output logic      [NUM_IN-1:0]    in_delayed,
   input  wire logic [NUM_SIG-1:0]   ev_on_en,
   input  wire logic [NUM_SIG-1:0]   ev_off_en,
   output logic                      ev_valid,
   output ev_group_t                 ev_group,
   output logic      [IN_IDX_W-1:0]  ev_index,
   output logic                      ev_on,
   output logic      [STAMP_W-1:0]   ev_stamp
);
   // group decode and pulse counter width refused at elaboration
   if (NUM_SIG != 3 * GROUP_SIZE || (1 << SIG_IDX_W) < NUM_SIG
       || PULSE_MS >= (1 << PULSE_CNT_W)) begin : g_bad_layout
      $error("virtual_signal_bank: group layout mismatch");
   end

   // lowest pending index; fixed priority is fair enough at one event per cycle
   function automatic logic [SIG_IDX_W-1:0] first_set(input logic [NUM_SIG-1:0] v);
      logic [SIG_IDX_W-1:0] idx;
      idx = '0;
      for (int i = NUM_SIG - 1; i >= 0; i--) begin
         if (v[i])
            idx = SIG_IDX_W'(i);
      end
      return idx;
   endfunction

   function automatic ev_group_t group_of(input logic [SIG_IDX_W-1:0] idx);
      if (idx < SIG_IDX_W'(GROUP_SIZE))
         return GRP_OUT_LOW;
      else if (idx < SIG_IDX_W'(NUM_OUT))
         return GRP_OUT_HIGH;
      else
         return GRP_IN;
   endfunction

   logic                 ms_tick;
   logic [STAMP_W-1:0]   ms_time;
   logic [NUM_IN-1:0]    next_in;
   logic [NUM_SIG-1:0]   pend;
   logic [NUM_SIG-1:0]   pol;
   logic [STAMP_W-1:0]   stamp_mem [NUM_SIG];

   ms_tick_gen #(.CYCLES(MS_CYCLES)) u_tick (
      .clk  (clk),
      .rstn (rstn),
      .tick (ms_tick)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         ms_time <= '0;
      else if (ms_tick)
         ms_time <= ms_time + 1'b1;
   end

   // outputs: registered copy feeds routing and supervisory readout
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         out_state <= '0;
      else
         out_state <= out_value; // R1 R2 R3
   end

   for (genvar i = 0; i < NUM_IN; i++) begin : g_in
      logic [PULSE_CNT_W-1:0] pulse_cnt;
      logic [STRETCH_W-1:0]   dly_cnt;
      wire hit    = cmd_valid && (cmd_index == IN_IDX_W'(i)); // R5
      wire set1   = hit && cmd_value;
      wire expire = in_pulse_mode[i] && in_state[i] && ms_tick
                    && (pulse_cnt == PULSE_TICKS - 1'b1); // R8
      // a zero command clears in either mode
      assign next_in[i] = hit ? cmd_value : (expire ? 1'b0 : in_state[i]); // R4 R7

      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn)
            pulse_cnt <= '0;
         else if (set1)
            pulse_cnt <= '0; // R13
         else if (ms_tick && in_state[i])
            pulse_cnt <= pulse_cnt + 1'b1; // R13
      end

      // falling-edge delay gate for lengthening short pulses
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            in_delayed[i] <= 1'b0;
            dly_cnt       <= '0;
         end else if (in_state[i]) begin
            in_delayed[i] <= 1'b1; // R9
            dly_cnt       <= stretch_ms;
         end else if (in_delayed[i]) begin
            if (dly_cnt == '0)
               in_delayed[i] <= 1'b0; // R9
            else if (ms_tick)
               dly_cnt <= dly_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         in_state <= IN_RESET; // R6
      else
         in_state <= next_in;
   end

   // event capture: change detected on the edge where the state is taken
   wire [NUM_SIG-1:0] sig_now  = {next_in, out_value};
   wire [NUM_SIG-1:0] sig_prev = {in_state, out_state};
   wire [NUM_SIG-1:0] change   = sig_now ^ sig_prev;
   wire [NUM_SIG-1:0] want     = change & ((sig_now & ev_on_en) | (~sig_now & ev_off_en)); // R10
   wire [SIG_IDX_W-1:0] pick   = first_set(pend);
   wire               found    = |pend;
   wire [NUM_SIG-1:0] clr      = found ? (NUM_SIG'(1) << pick) : '0;

   // a second change before the first is sent overwrites it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend <= '0;
         pol  <= '0;
      end else begin
         pend <= (pend & ~clr) | want; // R10
         pol  <= (pol & ~want) | (sig_now & want);
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_SIG; i++) begin
         if (want[i])
            stamp_mem[i] <= ms_time; // R11
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ev_valid <= 1'b0;
         ev_group <= GRP_OUT_LOW;
         ev_index <= '0;
         ev_on    <= 1'b0;
         ev_stamp <= '0;
      end else begin
         ev_valid <= found;
         ev_group <= group_of(pick); // R12
         ev_index <= pick[IN_IDX_W-1:0]; // R12
         ev_on    <= pol[pick];
         ev_stamp <= stamp_mem[pick]; // R11
      end
   end

   // helper: cycles input 0 has been high since its last command, in either mode
   localparam int PULSE_CYC = PULSE_MS * MS_CYCLES;
   logic [31:0] hi_cyc0;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         hi_cyc0 <= '0;
      else if (!in_state[0] || (cmd_valid && cmd_index == '0))
         hi_cyc0 <= '0;
      else
         hi_cyc0 <= hi_cyc0 + 1'b1;
   end

   a_reset_inputs_zero: assert property (@(posedge clk) $rose(rstn) |-> $past(in_state) == '0) // R6
      else $error("inputs not zero across reset");
   a_latch_set_hold: assert property (@(posedge clk) disable iff (!rstn)
      cmd_valid && cmd_value && !in_pulse_mode[cmd_index] |=> in_state[$past(cmd_index)]) // R7
      else $error("latching input did not go high");
   a_zero_cmd_clear: assert property (@(posedge clk) disable iff (!rstn)
      cmd_valid && !cmd_value |=> !in_state[$past(cmd_index)]) // R7
      else $error("zero command did not clear input");
   a_pulse_max_len: assert property (@(posedge clk) disable iff (!rstn)
      in_pulse_mode[0] |-> hi_cyc0 <= PULSE_CYC) // R8
      else $error("pulse longer than allowed");
   a_pulse_tick_min: assert property (@(posedge clk) disable iff (!rstn)
      $fell(in_state[0]) && $past(in_pulse_mode[0]) && !$past(cmd_valid)
      |-> $past(hi_cyc0) >= PULSE_CYC - MS_CYCLES) // R13
      else $error("pulse ended too early");
   a_delay_gate_hold: assert property (@(posedge clk) disable iff (!rstn)
      $fell(in_state[0]) |-> in_delayed[0]) // R9
      else $error("delayed input fell with input");
   a_out_mirror_path: assert property (@(posedge clk) disable iff (!rstn)
      ##1 out_state == $past(out_value)) // R1
      else $error("output state does not follow user logic");
   a_out_event_sent: assert property (@(posedge clk) disable iff (!rstn)
      out_value[0] && !out_state[0] && ev_on_en[0]
      |-> ##[1:100] (ev_valid && ev_group == GRP_OUT_LOW && ev_index == '0)) // R10
      else $error("output event not reported");
   a_stamp_not_future: assert property (@(posedge clk) disable iff (!rstn)
      ev_valid |-> ev_stamp <= ms_time) // R11
      else $error("event stamp later than current time");
   a_group_code_legal: assert property (@(posedge clk) disable iff (!rstn)
      ev_valid |-> ev_group != 2'h2) // R12
      else $error("illegal event group");
endmodule // virtual_signal_bank

/* design/vsig_pkg.sv */
// constants and types shared by the virtual signal bank
package vsig_pkg;
   localparam int NUM_OUT     = 64;
   localparam int NUM_IN      = 32;
   localparam int NUM_SIG     = NUM_OUT + NUM_IN;
   localparam int SIG_IDX_W   = 7;
   localparam int IN_IDX_W    = 5;
   localparam int GROUP_SIZE  = 32;
   localparam int CLK_HZ      = 50_000_000;
   localparam int MS_PER_S    = 1000;
   localparam int PULSE_MS    = 5;
   localparam int PULSE_CNT_W = 3;
   localparam int STAMP_W     = 32;
   localparam int STRETCH_W   = 8;
   localparam int TICK_CNT_W  = 17;
   localparam logic [PULSE_CNT_W-1:0] PULSE_TICKS = PULSE_CNT_W'(PULSE_MS);
   localparam logic [NUM_IN-1:0]      IN_RESET    = 32'h0000_0000;

   typedef enum logic [1:0] {
      GRP_OUT_LOW  = 2'h0,
      GRP_OUT_HIGH = 2'h1,
      GRP_IN       = 2'h3
   } ev_group_t;
endpackage

/* design/ms_tick_gen.sv */
// millisecond tick divider from the system clock
module ms_tick_gen
   import vsig_pkg::*;
#(
   parameter int CYCLES = CLK_HZ / MS_PER_S
) (
   input  wire logic clk,
   input  wire logic rstn,
   output logic      tick
);
   // refused at elaboration: the wrap compare needs at least two counts
   if (CYCLES < 2 || CYCLES >= (1 << TICK_CNT_W)) begin : g_bad_cycles
      $error("ms_tick_gen: CYCLES out of range");
   end

   logic [TICK_CNT_W-1:0] count;
   wire                   wrap = (count == TICK_CNT_W'(CYCLES - 1));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= wrap ? '0 : count + 1'b1;
         tick  <= wrap;
      end
   end
endmodule // ms_tick_gen

/* tb/cmd_source.sv */
// command source standing in for the operator switch and supervisory control
module cmd_source
   import vsig_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                go,
   input  wire logic [IN_IDX_W-1:0] idx,
   input  wire logic                val,
   output logic                     cmd_valid,
   output logic      [IN_IDX_W-1:0] cmd_index,
   output logic                     cmd_value
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd_valid = 1'b0;
      cmd_index = '0;
      cmd_value = 1'b0;
   end
   // states move only by strobed commands; idle fields toggle so no stale value helps
   always @(posedge clk) begin
      cmd_valid <= go;
      cmd_index <= go ? idx : ~cmd_index;
      cmd_value <= go ? val : ~cmd_value;
   end
endmodule // cmd_source

/* tb/tb.sv */
// self-checking bench for the virtual signal bank
module tb
   import vsig_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, go = 0, val = 0, cmd_valid, cmd_value, ev_valid, ev_on, seen;
   logic [IN_IDX_W-1:0] idx = '0, cmd_index, ev_index;
   logic [NUM_OUT-1:0]  out_value = '0, out_state;
   logic [NUM_IN-1:0]   in_pulse_mode = 32'h0000_0001, in_state, in_delayed;
   logic [NUM_SIG-1:0]  ev_on_en = 96'h1, ev_off_en = '0;
   logic [STAMP_W-1:0]  ev_stamp;
   ev_group_t           ev_group;
   localparam int MS = 10;
   int failures = 0, checks = 0, n, t0, cyc = 0;
   logic [63:0] rows [4] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'hA5A5_0F0F_5A5A_F0F0,
                             64'h8000_0000_0000_0001};
   always #10 clk = ~clk;
   // cycles since reset release, the bench's own clock for time stamps
   always @(posedge clk) cyc <= rstn ? cyc + 1 : 0;
   cmd_source i_cmd_source (.clk(clk), .go(go), .idx(idx), .val(val), .cmd_valid(cmd_valid),
      .cmd_index(cmd_index), .cmd_value(cmd_value));
   // short ms tick keeps the 5 ms pulse at about 50 cycles
   virtual_signal_bank #(.MS_CYCLES(MS)) i_virtual_signal_bank (.clk(clk), .rstn(rstn),
      .out_value(out_value), .out_state(out_state), .cmd_valid(cmd_valid),
      .cmd_index(cmd_index), .cmd_value(cmd_value), .in_pulse_mode(in_pulse_mode),
      .stretch_ms(8'h02), .in_state(in_state), .in_delayed(in_delayed), .ev_on_en(ev_on_en),
      .ev_off_en(ev_off_en), .ev_valid(ev_valid), .ev_group(ev_group), .ev_index(ev_index),
      .ev_on(ev_on), .ev_stamp(ev_stamp));
   task automatic chk(input string name, input logic [63:0] s, input logic [63:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmd(input logic [IN_IDX_W-1:0] i, input logic v);
      go <= 1'b1;
      idx <= i;
      val <= v;
      @(posedge clk);
      go <= 1'b0;
      // returns just after the edge that takes the command, so the event that follows is not missed
      @(posedge clk);
      #1;
   endtask
   // bounded wait for one event pulse
   task automatic wait_ev(input int lim);
      seen = 0;
      for (int k = 0; k < lim && !seen; k++) begin
         @(posedge clk);
         #1 seen = (ev_valid === 1'b1);
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[r]) begin
         @(posedge clk);
         out_value <= rows[r];
         repeat (2) @(posedge clk);
         #1 chk("out_state", out_state, rows[r]);
      end
      $display("output table done");
      @(posedge clk);
      t0 = cyc;
      out_value <= 64'h0000_0100_0000_0000;
      ev_on_en <= 96'h1 << 40;
      ev_off_en <= 96'h1 << 67;
      wait_ev(200);
      chk("out_on_event", {seen, ev_group, ev_index, ev_on}, {1'b1, 2'h1, 5'h08, 1'b1});
      chk("stamp", int'(ev_stamp) >= t0 / MS - 1 && int'(ev_stamp) <= t0 / MS + 1, 1'b1);
      cmd(3, 1'b1);
      repeat (60) @(posedge clk);
      #1 chk("latched", in_state[3], 1'b1);
      cmd(3, 1'b0);
      chk("cleared", in_state[3], 1'b0);
      wait_ev(200);
      chk("in_off_event", {seen, ev_group, ev_index, ev_on}, {1'b1, 2'h3, 5'h03, 1'b0});
      @(posedge clk);
      out_value <= '0;
      wait_ev(150);
      chk("off_masked", seen, 1'b0);
      $display("event test done");
      // pulse high time must lie between 4 and 5 ms of ticks
      cmd(0, 1'b1);
      for (n = 0; n < 100 && in_state[0] === 1'b1; n++) @(posedge clk) #1;
      chk("pulse_len", n >= (PULSE_MS - 1) * MS && n <= PULSE_MS * MS, 1'b1);
      cmd(0, 1'b1);
      repeat (3 * MS) @(posedge clk);
      cmd(0, 1'b1);
      for (n = 0; n < 100 && in_state[0] === 1'b1; n++) @(posedge clk) #1;
      chk("restart_len", n >= (PULSE_MS - 1) * MS && n <= PULSE_MS * MS, 1'b1);
      repeat (MS - 1) @(posedge clk);
      #1 chk("stretched", in_delayed[0], 1'b1);
      repeat (2 * MS + 1) @(posedge clk);
      #1 chk("stretch_end", in_delayed[0], 1'b0);
      $display("pulse test done");
      cmd(7, 1'b1);
      chk("latched7", in_state[7], 1'b1);
      rstn <= 1'b0;
      #3 chk("reboot", in_state, IN_RESET);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("after_reboot", {in_state, ev_valid}, {IN_RESET, 1'b0});
      $display("reset test done");
      end_sim();
   end
endmodule // tb
